// ==== logic/pvms_pkg.sv ====
// shared constants and carriers for the vendor mode/status register bank
package pvms_pkg;
    // register indices on the management port
    localparam logic [4:0] PVMS_IDX_MODE_CTRL = 5'h11;
    localparam logic [4:0] PVMS_IDX_SPECIAL = 5'h12;
    localparam logic [4:0] PVMS_IDX_SYMERR = 5'h1a;
    localparam logic [4:0] PVMS_IDX_XOVER = 5'h1b;

    // mode_control_state fields
    localparam int PVMS_EDPD_BIT = 13;
    localparam int PVMS_FARLB_BIT = 9;
    localparam int PVMS_ALTIRQ_BIT = 6;
    localparam int PVMS_ENERGY_BIT = 1;
    localparam int PVMS_MCS_RSV_BIT = 0;
    // special_operating_modes fields
    localparam int PVMS_SPM_RSV_BIT = 14;
    localparam int PVMS_MODE_LSB = 5;
    localparam int PVMS_ADDR_LSB = 0;
    // crossover_polarity_ctrl fields
    localparam int PVMS_XDIS_BIT = 15;
    localparam int PVMS_PAIR_BIT = 13;
    localparam int PVMS_SQE_BIT = 11;
    localparam int PVMS_POL_BIT = 4;

    // reset values
    localparam logic PVMS_RST_EDPD = 1'h0;
    localparam logic PVMS_RST_FARLB = 1'h0;
    localparam logic PVMS_RST_ALTIRQ = 1'h0;
    localparam logic PVMS_RST_ENERGY = 1'h1;
    localparam logic PVMS_RST_MCS_RSV = 1'h0;
    localparam logic PVMS_RST_SPM_RSV = 1'h1;
    localparam logic [2:0] PVMS_RST_MODE = 3'h0;
    localparam logic [4:0] PVMS_RST_ADDR = 5'h00;
    localparam logic PVMS_RST_XDIS = 1'h0;
    localparam logic PVMS_RST_PAIR = 1'h0;
    localparam logic PVMS_RST_SQE = 1'h0;
    localparam logic [15:0] PVMS_RST_SYMERR = 16'h0000;

    // timing
    localparam int PVMS_CLK_HZ = 20_000_000;
    localparam int PVMS_ENERGY_TIMEOUT_MS = 256;
    localparam int PVMS_ENERGY_TIMEOUT_CYC = PVMS_ENERGY_TIMEOUT_MS * (PVMS_CLK_HZ / 1000);
    localparam logic [1:0] PVMS_STRAP_SETTLE = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] idx;
        logic [15:0] wdata;
    } pvms_reg_req_t;

    typedef struct packed {
        logic link_100;
        logic in_packet;
        logic symbol_invalid;
        logic polarity_rev;
        logic auto_swap;
    } pvms_line_stat_t;
endpackage : pvms_pkg

// ==== logic/pvms_energy_timer.sv ====
// line energy presence flag with silence timeout
`timescale 1ns/1ps
`default_nettype none
module pvms_energy_timer
    import pvms_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = PVMS_ENERGY_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic energy_raw,
    output logic present
);
    initial
    begin
        if (TIMEOUT_CYCLES < 1)
            $error("energy timeout must be at least one cycle");
    end

    logic energy_meta;
    logic energy_seen;
    logic [31:0] quiet_cnt;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            energy_meta <= 1'h0;
            energy_seen <= 1'h0;
        end
        else
        begin
            energy_meta <= energy_raw;
            energy_seen <= energy_meta;
        end
    end

    // only a hardware reset touches this flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quiet_cnt <= 32'h0;
            present <= PVMS_RST_ENERGY;
        end
        else if (energy_seen)
        begin
            quiet_cnt <= 32'h0;
            present <= 1'h1;
        end
        else if (quiet_cnt == 32'(TIMEOUT_CYCLES - 1))
            present <= 1'h0;
        else
            quiet_cnt <= quiet_cnt + 32'h1;
    end

    a_energy_fall: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(present) |-> $past(quiet_cnt) == 32'(TIMEOUT_CYCLES - 1))
        else $error("energy flag fell before the silence timeout");
endmodule : pvms_energy_timer
`default_nettype wire

// ==== logic/pvms_symerr_counter.sv ====
// invalid symbol counter, once per packet, wrapping
`timescale 1ns/1ps
`default_nettype none
module pvms_symerr_counter
    import pvms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic link_100,
    input wire logic in_packet,
    input wire logic symbol_invalid,
    output logic [15:0] count
);
    logic counted;
    logic bump;

    // idle symbols count each time, a packet only once
    assign bump = symbol_invalid && link_100 && !(in_packet && counted);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            counted <= 1'h0;
        else if (clear || !in_packet)
            counted <= 1'h0;
        else if (bump)
            counted <= 1'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= PVMS_RST_SYMERR;
        else if (clear)
            count <= PVMS_RST_SYMERR;
        else if (bump)
            count <= 16'(count + 16'h1);
    end

    a_symerr_tenbase: assert property (@(posedge clk) disable iff (!rst_n)
        !link_100 && !clear |=> $stable(count))
        else $error("symbol counter moved in 10 Mb/s mode");
    a_symerr_once: assert property (@(posedge clk) disable iff (!rst_n)
        in_packet && counted && !clear |=> $stable(count))
        else $error("symbol counter moved twice in one packet");
    a_symerr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        count == 16'hffff && bump && !clear |=> count == 16'h0000)
        else $error("symbol counter did not wrap to zero");
endmodule : pvms_symerr_counter
`default_nettype wire

// ==== logic/pvms_regs.sv ====
// vendor mode, address, symbol error and crossover registers
// Behaviour
// - mode bit 13 enables energy-detect power-down; resets to zero.
// - mode bit 9 loops received data back to line, 100 Mb/s only.
// - far loopback keeps working while isolate is set.
// - mode bit 6 selects alternate interrupt scheme; zero is primary.
// - energy flag bit 1 drops after 256 ms without line energy.
// - hardware reset sets energy flag; software reset leaves it alone.
// - special bits 7:5 hold the writable transceiver mode.
// - mode field resets from the three mode straps.
// - special bits 4:0 hold address for frame match and scrambler seed.
// - address field resets from the lowest address strap.
// - 16-bit counter counts invalid symbols at 100 Mb/s, idle included.
// - counter advances at most once per received packet.
// - counter wraps to zero past its maximum.
// - counter clears on reset; reading leaves it unchanged.
// - counter holds still in 10 Mb/s mode.
// - crossover bit 15 zero is automatic; one uses manual bit 13.
// - manual bit 13 zero is straight pairs, one swaps pairs.
// - crossover bit 11 set disables the heartbeat test.
// - crossover bit 4 reports reversed 10 Mb/s receive polarity.
`timescale 1ns/1ps
`default_nettype none
module pvms_regs
    import pvms_pkg::*;
#(
    parameter int ENERGY_TIMEOUT_CYCLES = PVMS_ENERGY_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire pvms_reg_req_t req,
    input wire pvms_line_stat_t line_stat,
    input wire logic energy_raw,
    input wire logic [2:0] mode_strap,
    input wire logic addr_strap0,
    input wire logic isolate,
    input wire logic [4:0] frame_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic energy_detect_powerdown_en,
    output logic line_side_loopback_en,
    output logic loopback_active,
    output logic alternate_irq_select,
    output logic line_energy_present,
    output logic [2:0] transceiver_mode,
    output logic [4:0] management_station_address,
    output logic [4:0] scrambler_seed,
    output logic frame_addr_match,
    output logic auto_crossover_disable,
    output logic manual_pair_swap,
    output logic pair_swap,
    output logic heartbeat_test_disable,
    output logic receive_polarity_reversed
);
    initial
    begin
        if (ENERGY_TIMEOUT_CYCLES < 1)
            $error("energy timeout must be at least one cycle");
    end

    function automatic logic write_to(input pvms_reg_req_t r, input logic [4:0] idx);
        write_to = r.wr && (r.idx == idx);
    endfunction : write_to

    logic mcs_rsv;
    logic spm_rsv;
    logic energy_flag;
    logic [15:0] symerr_count;
    logic [2:0] mode_meta;
    logic [2:0] mode_sync;
    logic addr_meta;
    logic addr_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic strap_take;
    logic [15:0] next_rd_data;
    logic first_cycle;

    // energy presence and symbol errors
    pvms_energy_timer #(
        .TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)
    ) u_energy (
        .clk(clk),
        .rst_n(rst_n),
        .energy_raw(energy_raw),
        .present(energy_flag)
    );

    pvms_symerr_counter u_symerr (
        .clk(clk),
        .rst_n(rst_n),
        .clear(soft_reset),
        .link_100(line_stat.link_100),
        .in_packet(line_stat.in_packet),
        .symbol_invalid(line_stat.symbol_invalid),
        .count(symerr_count)
    );

    // strap pins cross into the clock domain first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_meta <= 3'h0;
            mode_sync <= 3'h0;
            addr_meta <= 1'h0;
            addr_sync <= 1'h0;
        end
        else
        begin
            mode_meta <= mode_strap;
            mode_sync <= mode_meta;
            addr_meta <= addr_strap0;
            addr_sync <= addr_meta;
        end
    end

    // straps are caught once, after the synchroniser has filled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_cnt <= 2'h0;
            strap_done <= 1'h0;
        end
        else if (!strap_done)
        begin
            strap_cnt <= 2'(strap_cnt + 2'h1);
            strap_done <= (strap_cnt == PVMS_STRAP_SETTLE);
        end
    end

    assign strap_take = !strap_done && (strap_cnt == PVMS_STRAP_SETTLE);

    // mode_control_state: soft reset returns these to defaults
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            energy_detect_powerdown_en <= PVMS_RST_EDPD;
            line_side_loopback_en <= PVMS_RST_FARLB;
            alternate_irq_select <= PVMS_RST_ALTIRQ;
            mcs_rsv <= PVMS_RST_MCS_RSV;
        end
        else if (soft_reset)
        begin
            energy_detect_powerdown_en <= PVMS_RST_EDPD;
            line_side_loopback_en <= PVMS_RST_FARLB;
            alternate_irq_select <= PVMS_RST_ALTIRQ;
            mcs_rsv <= PVMS_RST_MCS_RSV;
        end
        else if (write_to(req, PVMS_IDX_MODE_CTRL))
        begin
            energy_detect_powerdown_en <= req.wdata[PVMS_EDPD_BIT];
            line_side_loopback_en <= req.wdata[PVMS_FARLB_BIT];
            alternate_irq_select <= req.wdata[PVMS_ALTIRQ_BIT];
            mcs_rsv <= req.wdata[PVMS_MCS_RSV_BIT];
        end
    end

    // energy flag mirrors the timer; soft reset has no path here
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            line_energy_present <= PVMS_RST_ENERGY;
        else
            line_energy_present <= energy_flag;
    end

    // loopback in 100 Mb/s only; isolate deliberately not consulted
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            loopback_active <= 1'h0;
        else
            loopback_active <= line_side_loopback_en && line_stat.link_100;
    end

    // special_operating_modes: kept over soft reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spm_rsv <= PVMS_RST_SPM_RSV;
            transceiver_mode <= PVMS_RST_MODE;
            management_station_address <= PVMS_RST_ADDR;
        end
        else if (strap_take)
        begin
            transceiver_mode <= mode_sync;
            management_station_address <= {4'h0, addr_sync};
        end
        else if (write_to(req, PVMS_IDX_SPECIAL))
        begin
            spm_rsv <= req.wdata[PVMS_SPM_RSV_BIT];
            transceiver_mode <= req.wdata[PVMS_MODE_LSB +: 3];
            management_station_address <= req.wdata[PVMS_ADDR_LSB +: 5];
        end
    end

    // address uses: frame compare and scrambler key seed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_addr_match <= 1'h0;
            scrambler_seed <= PVMS_RST_ADDR;
        end
        else
        begin
            frame_addr_match <= (frame_addr == management_station_address);
            scrambler_seed <= management_station_address;
        end
    end

    // crossover_polarity_ctrl writable fields
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_crossover_disable <= PVMS_RST_XDIS;
            manual_pair_swap <= PVMS_RST_PAIR;
            heartbeat_test_disable <= PVMS_RST_SQE;
        end
        else if (soft_reset)
        begin
            auto_crossover_disable <= PVMS_RST_XDIS;
            manual_pair_swap <= PVMS_RST_PAIR;
        end
        else if (write_to(req, PVMS_IDX_XOVER))
        begin
            auto_crossover_disable <= req.wdata[PVMS_XDIS_BIT];
            manual_pair_swap <= req.wdata[PVMS_PAIR_BIT];
            heartbeat_test_disable <= req.wdata[PVMS_SQE_BIT];
        end
    end

    // pair assignment and polarity status
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pair_swap <= 1'h0;
            receive_polarity_reversed <= 1'h0;
        end
        else
        begin
            pair_swap <= auto_crossover_disable ? manual_pair_swap
                                                : line_stat.auto_swap;
            receive_polarity_reversed <= line_stat.polarity_rev;
        end
    end

    // read word assembly; unlisted bits stay zero
    always_comb
    begin
        next_rd_data = 16'h0000;
        case (req.idx)
            PVMS_IDX_MODE_CTRL:
            begin
                next_rd_data[PVMS_EDPD_BIT] = energy_detect_powerdown_en;
                next_rd_data[PVMS_FARLB_BIT] = line_side_loopback_en;
                next_rd_data[PVMS_ALTIRQ_BIT] = alternate_irq_select;
                next_rd_data[PVMS_ENERGY_BIT] = line_energy_present;
                next_rd_data[PVMS_MCS_RSV_BIT] = mcs_rsv;
            end
            PVMS_IDX_SPECIAL:
            begin
                next_rd_data[PVMS_SPM_RSV_BIT] = spm_rsv;
                next_rd_data[PVMS_MODE_LSB +: 3] = transceiver_mode;
                next_rd_data[PVMS_ADDR_LSB +: 5] = management_station_address;
            end
            PVMS_IDX_SYMERR:
                next_rd_data = symerr_count;
            PVMS_IDX_XOVER:
            begin
                next_rd_data[PVMS_XDIS_BIT] = auto_crossover_disable;
                next_rd_data[PVMS_PAIR_BIT] = manual_pair_swap;
                next_rd_data[PVMS_SQE_BIT] = heartbeat_test_disable;
                next_rd_data[PVMS_POL_BIT] = receive_polarity_reversed;
            end
            default:
                next_rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= 16'h0000;
            rd_valid <= 1'h0;
        end
        else
        begin
            rd_valid <= req.rd;
            if (req.rd)
                rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            first_cycle <= 1'h1;
        else
            first_cycle <= 1'h0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_mode_wr;
        write_to(req, PVMS_IDX_MODE_CTRL) && !soft_reset;
    endsequence
    sequence s_spm_wr;
        write_to(req, PVMS_IDX_SPECIAL) && !strap_take;
    endsequence
    sequence s_xover_wr;
        write_to(req, PVMS_IDX_XOVER) && !soft_reset;
    endsequence

    a_edpd_write: assert property (s_mode_wr |=>
        energy_detect_powerdown_en == $past(req.wdata[PVMS_EDPD_BIT]))
        else $error("power-down enable did not take the written value");
    a_edpd_soft: assert property (soft_reset |=> !energy_detect_powerdown_en)
        else $error("power-down enable survived a soft reset");
    a_loop_speed: assert property (line_side_loopback_en && !line_stat.link_100 |=>
        !loopback_active)
        else $error("loopback active outside 100 Mb/s");
    a_loop_isolate: assert property (line_side_loopback_en && line_stat.link_100
        && isolate |=> loopback_active)
        else $error("isolate stopped far loopback");
    a_altirq_write: assert property (s_mode_wr |=>
        alternate_irq_select == $past(req.wdata[PVMS_ALTIRQ_BIT]))
        else $error("interrupt scheme select did not take the write");
    a_energy_hw: assert property (first_cycle |-> line_energy_present)
        else $error("energy flag not set after hardware reset");
    a_energy_track: assert property (##1 $changed(energy_flag) |=>
        line_energy_present == $past(energy_flag))
        else $error("energy flag register lost track of the timer");
    a_mode_write: assert property (s_spm_wr |=>
        transceiver_mode == $past(req.wdata[PVMS_MODE_LSB +: 3]))
        else $error("mode field did not take the write");
    a_mode_strap: assert property (strap_take |=> transceiver_mode == $past(mode_sync))
        else $error("mode field not loaded from straps");
    a_addr_strap: assert property (strap_take |=>
        management_station_address == {4'h0, $past(addr_sync)})
        else $error("address field not loaded from strap");
    a_addr_match: assert property (frame_addr == management_station_address |=>
        frame_addr_match ##1 scrambler_seed == $past(management_station_address))
        else $error("address compare or scrambler seed wrong");
    a_symerr_read: assert property (req.rd && req.idx == PVMS_IDX_SYMERR && !soft_reset
        && !line_stat.symbol_invalid |=> $stable(symerr_count))
        else $error("reading the symbol counter changed it");
    a_pair_manual: assert property (auto_crossover_disable |=>
        pair_swap == $past(manual_pair_swap))
        else $error("manual pair select ignored");
    a_pair_auto: assert property (!auto_crossover_disable |=>
        pair_swap == $past(line_stat.auto_swap))
        else $error("automatic crossover decision ignored");
    a_sqe_write: assert property (s_xover_wr |=>
        heartbeat_test_disable == $past(req.wdata[PVMS_SQE_BIT]))
        else $error("heartbeat disable did not take the write");
    a_pol_read: assert property (req.rd && req.idx == PVMS_IDX_XOVER |=>
        rd_valid && rd_data[PVMS_POL_BIT] == $past(receive_polarity_reversed))
        else $error("polarity status misreported");
    a_rsv_zero: assert property (req.rd && req.idx == PVMS_IDX_MODE_CTRL |=>
        rd_data[15:14] == 2'h0 && rd_data[12:10] == 3'h0 && rd_data[8:7] == 2'h0
        && rd_data[5:2] == 4'h0)
        else $error("reserved read-only bits not zero");
    a_symerr_ro: assert property (req.wr && req.idx == PVMS_IDX_SYMERR && !soft_reset
        && !line_stat.symbol_invalid |=> $stable(symerr_count))
        else $error("write altered the read-only counter");
endmodule : pvms_regs
`default_nettype wire

// ==== sim/pvms_mgmt_model.sv ====
// management station model driving the register port
`timescale 1ns/1ps
`default_nettype none
module pvms_mgmt_model
    import pvms_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    output var pvms_reg_req_t req
);
    initial req = '0;
    task automatic write_reg(input logic [4:0] idx, input logic [15:0] d);
        logic [15:0] w;
        begin
            w = d;
            if (idx == PVMS_IDX_SPECIAL) w[PVMS_SPM_RSV_BIT] = 1'b1;
            @(posedge clk);
            #1 req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: w};
            @(posedge clk);
            #1 req = '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~w};
        end
    endtask : write_reg
    task automatic read_reg(input logic [4:0] idx, output logic [15:0] v);
        begin
            @(posedge clk);
            #1 req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 16'h0000};
            @(posedge clk);
            #1 req = '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: 16'hffff};
            // answer stands from the taking edge to the next one
            v = rd_valid ? rd_data : 16'hdead;
            if (idx == PVMS_IDX_SPECIAL) v[PVMS_SPM_RSV_BIT] = 1'b0;
        end
    endtask : read_reg
endmodule : pvms_mgmt_model
`default_nettype wire

// ==== sim/test_pvms_regs.sv ====
// self-checking bench for the vendor mode/status register bank
`timescale 1ns/1ps
`default_nettype none
module test_pvms_regs;
    import pvms_pkg::*;
    localparam int TMO = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    pvms_reg_req_t req;
    pvms_line_stat_t ls = '0;
    logic energy_raw = 1'b1;
    logic [2:0] mode_strap = 3'h5;
    logic addr_strap0 = 1'b1;
    logic isolate = 1'b0;
    logic [4:0] frame_addr = 5'h00;
    logic [15:0] rd_data;
    logic rd_valid, edpd, lb_en, lb_act, alt, present, amatch;
    logic xdis, mswap, swap, hb_dis, pol;
    logic [2:0] tmode;
    logic [4:0] maddr, seed;
    int error_cnt = 0;
    int n_compared = 0;

    always #25 clk = ~clk;

    pvms_regs #(.ENERGY_TIMEOUT_CYCLES(TMO)) u_pvms_regs (
        .clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .req(req), .line_stat(ls),
        .energy_raw(energy_raw), .mode_strap(mode_strap), .addr_strap0(addr_strap0),
        .isolate(isolate), .frame_addr(frame_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .energy_detect_powerdown_en(edpd), .line_side_loopback_en(lb_en),
        .loopback_active(lb_act), .alternate_irq_select(alt), .line_energy_present(present),
        .transceiver_mode(tmode), .management_station_address(maddr),
        .scrambler_seed(seed), .frame_addr_match(amatch), .auto_crossover_disable(xdis),
        .manual_pair_swap(mswap), .pair_swap(swap), .heartbeat_test_disable(hb_dis),
        .receive_polarity_reversed(pol));

    pvms_mgmt_model u_pvms_mgmt_model (
        .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));

    task automatic end_of_test;
        begin
            if (error_cnt == 0 && n_compared > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            n_compared++;
            if (got !== exp)
            begin
                error_cnt++;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask : chk

    task automatic rchk(input logic [4:0] idx, input logic [15:0] exp);
        logic [15:0] v;
        begin
            u_pvms_mgmt_model.read_reg(idx, v);
            chk(v, exp);
        end
    endtask : rchk

    task automatic cyc(input int n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask : cyc

    task automatic wreg(input logic [4:0] idx, input logic [15:0] d);
        begin
            u_pvms_mgmt_model.write_reg(idx, d);
        end
    endtask : wreg

    task automatic t_reset;
        begin
            cyc(6);
            rchk(PVMS_IDX_MODE_CTRL, 16'h0002);
            rchk(PVMS_IDX_SPECIAL, 16'h00a1);
            chk({maddr, tmode}, {5'h01, 3'h5});
            rchk(PVMS_IDX_SYMERR, 16'h0000);
            rchk(PVMS_IDX_XOVER, 16'h0000);
            rchk(5'h05, 16'h0000);
        end
    endtask : t_reset

    task automatic t_mode;
        begin
            wreg(PVMS_IDX_MODE_CTRL, 16'hffff);
            rchk(PVMS_IDX_MODE_CTRL, 16'h2243);
            chk({edpd, lb_en, alt}, 3'h7);
            ls.link_100 = 1'b1;
            isolate = 1'b1;
            cyc(3);
            chk(lb_act, 1'b1);
            ls.link_100 = 1'b0;
            cyc(3);
            chk(lb_act, 1'b0);
            isolate = 1'b0;
            wreg(PVMS_IDX_MODE_CTRL, 16'h0000);
            chk({edpd, lb_en, alt}, 3'h0);
        end
    endtask : t_mode

    task automatic t_special;
        begin
            wreg(PVMS_IDX_SPECIAL, 16'hbf73);
            rchk(PVMS_IDX_SPECIAL, 16'h0073);
            chk(tmode, 3'h3);
            frame_addr = 5'h13;
            cyc(2);
            chk({amatch, seed}, {1'b1, 5'h13});
            frame_addr = 5'h12;
            cyc(2);
            chk(amatch, 1'b0);
        end
    endtask : t_special

    task automatic t_xover;
        begin
            ls.polarity_rev = 1'b1;
            wreg(PVMS_IDX_XOVER, 16'hffff);
            rchk(PVMS_IDX_XOVER, 16'ha810);
            chk({swap, hb_dis, xdis, mswap}, 4'hf);
            wreg(PVMS_IDX_XOVER, 16'h0000);
            ls.auto_swap = 1'b1;
            cyc(2);
            chk({swap, hb_dis}, 2'h2);
            ls.auto_swap = 1'b0;
            ls.polarity_rev = 1'b0;
            cyc(2);
            chk({swap, pol}, 2'h0);
        end
    endtask : t_xover

    task automatic t_energy;
        begin
            energy_raw = 1'b0;
            cyc(TMO + 8);
            chk(present, 1'b0);
            rchk(PVMS_IDX_MODE_CTRL, 16'h0000);
            energy_raw = 1'b1;
            cyc(4);
            chk(present, 1'b1);
            wreg(PVMS_IDX_MODE_CTRL, 16'h2241);
            energy_raw = 1'b0;
            soft_reset = 1'b1;
            cyc(1);
            soft_reset = 1'b0;
            rchk(PVMS_IDX_MODE_CTRL, 16'h0002);
            rchk(PVMS_IDX_SPECIAL, 16'h0073);
        end
    endtask : t_energy

    task automatic t_symerr;
        begin
            ls.link_100 = 1'b1;
            ls.in_packet = 1'b1;
            ls.symbol_invalid = 1'b1;
            cyc(3);
            ls.symbol_invalid = 1'b0;
            rchk(PVMS_IDX_SYMERR, 16'h0001);
            ls.in_packet = 1'b0;
            ls.symbol_invalid = 1'b1;
            cyc(2);
            ls.symbol_invalid = 1'b0;
            rchk(PVMS_IDX_SYMERR, 16'h0003);
            rchk(PVMS_IDX_SYMERR, 16'h0003);
            wreg(PVMS_IDX_SYMERR, 16'h1234);
            rchk(PVMS_IDX_SYMERR, 16'h0003);
            ls.link_100 = 1'b0;
            ls.symbol_invalid = 1'b1;
            cyc(4);
            ls.symbol_invalid = 1'b0;
            rchk(PVMS_IDX_SYMERR, 16'h0003);
            ls.link_100 = 1'b1;
            ls.symbol_invalid = 1'b1;
            cyc(65533);
            ls.symbol_invalid = 1'b0;
            rchk(PVMS_IDX_SYMERR, 16'h0000);
        end
    endtask : t_symerr

    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        end_of_test;
    end

    initial
    begin
        cyc(8);
        rst_n = 1'b1;
        t_reset;
        t_mode;
        t_special;
        t_xover;
        t_energy;
        t_symerr;
        end_of_test;
    end
endmodule : test_pvms_regs
`default_nettype wire
